//--- verilog/processor_feature_control.sv
// Feature control bank: query and update calls over selectable feature groups,
// plus error promotion and steering outputs driven by the current settings.
// Assumes call strobes and event inputs are synchronous to clk.
//
// What this block does
// - Groups 0..15 are architected; 16 and up are implementation-specific, ascending.
// - Query of unsupported architected group answers invalid-argument status.
// - Group above the largest supported group (16) answers beyond-maximum status.
// - Valid query returns implemented, current-setting and controllable masks.
// - Update changes only bits both implemented and controllable.
// - Controllable features hold zero after reset hand-off.
// - Machine-check and init entries leave feature settings unchanged.
// - Bit 63 promotes bus errors onto bus-init pin when signalling enabled.
// - Bit 62 promotes machine check aborts onto bus-error pin when enabled.
// - Bit 61 promotes machine check aborts onto bus-init pin when enabled.
// - Bit 60 promotes corrected interrupts to aborts when abort signalling enabled, then further promotion applies.
// - Bit 59 disables cache: memory access always, no coherence, snoops miss.
// - Bit 58 answers coherency requests as line absent.
// - Bit 57 set keeps every functional unit clocked.
// - Bit 56 set drops internal time-outs instead of raising bus init.
// - Bit 55 set enables external environmental error notification.
// - Bit 47 set makes execution wait for known branch targets.
// - Bit 46 set allows instruction fetch only when needed or hinted.
// - Bit 45 set allows data fetch only when needed or explicitly fetched.
// - Setting an unsettable feature is silently ignored.
`include "feature_ctl_regs.svh"
`default_nettype none

module processor_feature_control (
    input wire logic clk,
    input wire logic nrst,
    input wire logic query_call,
    input wire logic update_call,
    input wire logic [7:0] feature_group,
    input wire logic [63:0] update_value,
    input wire logic error_check_entry,
    input wire logic init_event_entry,
    input wire logic bus_error_event,
    input wire logic mca_event,
    input wire logic cmci_event,
    input wire logic timeout_event,
    input wire logic env_error_event,
    input wire logic bus_error_signal_signal_en,
    input wire logic bus_init_signal_signal_en,
    input wire logic mca_signal_en,
    output logic ans_valid,
    output logic [63:0] ans_avail,
    output logic [63:0] ans_status,
    output logic [63:0] ans_control,
    output logic [7:0] ans_code,
    output logic bus_error_signal,
    output logic bus_init_signal,
    output logic machine_check_abort,
    output logic env_notify,
    output logic cache_disable,
    output logic coherency_disable,
    output logic dynamic_power_gating_en,
    output logic branch_predict_off,
    output logic ifetch_prefetch_off,
    output logic dfetch_prefetch_off
);
    feature_ctl_pkg::state_s s_r;
    feature_ctl_pkg::state_s s_nxt;

    // Masks are fixed; zero outside the implemented bits covers reserved positions
    localparam logic [63:0] G0_AVAIL = `FC_G0_AVAIL;
    localparam logic [63:0] G0_CTRL = `FC_G0_CTRL & `FC_G0_AVAIL;
    localparam logic [63:0] G16_AVAIL = `FC_G16_AVAIL;
    localparam logic [63:0] G16_CTRL = `FC_G16_CTRL & `FC_G16_AVAIL;

    logic eff_mca;
    logic [63:0] g0;

    always_comb begin
        s_nxt = s_r;
        g0 = s_r.g0_r;
        s_nxt.ans_valid_r = 1'b0;
        // Error and init entries have no path here, so settings survive them
        if (update_call) begin
            // Writable bits merge; others and reserved are silently kept
            if (feature_group == 8'h00) begin
                s_nxt.g0_r = (s_r.g0_r & ~G0_CTRL) | (update_value & G0_CTRL);
            end else if (feature_group == `FC_GROUP_MAX) begin
                s_nxt.g16_r = (s_r.g16_r & ~G16_CTRL) | (update_value & G16_CTRL);
            end
        end
        // Steering follows the new setting in the same cycle as the answer
        g0 = s_nxt.g0_r;
        if (query_call || update_call) begin
            s_nxt.ans_valid_r = 1'b1;
            s_nxt.ans_r = '0;
            if (feature_group == 8'h00) begin
                s_nxt.ans_r.avail = G0_AVAIL;
                s_nxt.ans_r.status = query_call ? s_r.g0_r : s_nxt.g0_r;
                s_nxt.ans_r.control = G0_CTRL;
                s_nxt.ans_r.code = `FC_ST_OK;
            end else if (feature_group == `FC_GROUP_MAX) begin
                s_nxt.ans_r.avail = G16_AVAIL;
                s_nxt.ans_r.status = query_call ? s_r.g16_r : s_nxt.g16_r;
                s_nxt.ans_r.control = G16_CTRL;
                s_nxt.ans_r.code = `FC_ST_OK;
            end else if (feature_group <= `FC_GROUP_ARCH_LAST) begin
                // Unsupported architected group: no masks returned
                s_nxt.ans_r.code = `FC_ST_INVALID;
            end else if (feature_group < `FC_GROUP_MAX) begin
                s_nxt.ans_r.code = `FC_ST_OK_LARGER;
            end else begin
                s_nxt.ans_r.code = `FC_ST_BEYOND_MAX;
            end
        end
        // Corrected interrupt raised to abort only if abort signalling is on
        eff_mca = mca_event | (cmci_event & g0[`FC_BIT_CMCI_PROMO] & mca_signal_en);
        s_nxt.pins_r.machine_check_abort = eff_mca & mca_signal_en;
        s_nxt.pins_r.bus_error_signal = (bus_error_event | (eff_mca & g0[`FC_BIT_MCA_BUS_ERROR_SIGNAL]))
            & bus_error_signal_signal_en;
        s_nxt.pins_r.bus_init_signal = ((bus_error_event & g0[`FC_BIT_BUS_ERROR_SIGNAL_PROMO])
            | (eff_mca & g0[`FC_BIT_MCA_BUS_INIT_SIGNAL])
            | (timeout_event & ~g0[`FC_BIT_TIMEOUT_QUIET]))
            & bus_init_signal_signal_en;
        s_nxt.steer_r[0] = env_error_event & g0[`FC_BIT_ENV_NOTIFY];
        s_nxt.steer_r[1] = g0[`FC_BIT_CACHE_OFF];
        s_nxt.steer_r[2] = g0[`FC_BIT_CACHE_OFF] | g0[`FC_BIT_COHER_OFF];
        s_nxt.steer_r[3] = ~g0[`FC_BIT_PWR_GATE_OFF];
        s_nxt.steer_r[4] = g0[`FC_BIT_BRANCH_WAIT];
        s_nxt.steer_r[5] = g0[`FC_BIT_IFETCH_DEMAND];
        s_nxt.steer_r[6] = g0[`FC_BIT_DFETCH_DEMAND];
        s_nxt.steer_r[7] = 1'b0;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.g0_r <= `FC_RESET_VALUE;
            s_r.g16_r <= `FC_RESET_VALUE;
            s_r.steer_r <= `FC_STEER_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ans_valid = s_r.ans_valid_r;
    assign ans_avail = s_r.ans_r.avail;
    assign ans_status = s_r.ans_r.status;
    assign ans_control = s_r.ans_r.control;
    assign ans_code = s_r.ans_r.code;
    assign bus_error_signal = s_r.pins_r.bus_error_signal;
    assign bus_init_signal = s_r.pins_r.bus_init_signal;
    assign machine_check_abort = s_r.pins_r.machine_check_abort;
    assign env_notify = s_r.steer_r[0];
    assign cache_disable = s_r.steer_r[1];
    assign coherency_disable = s_r.steer_r[2];
    assign dynamic_power_gating_en = s_r.steer_r[3];
    assign branch_predict_off = s_r.steer_r[4];
    assign ifetch_prefetch_off = s_r.steer_r[5];
    assign dfetch_prefetch_off = s_r.steer_r[6];
endmodule
`default_nettype wire

//--- common/feature_ctl_regs.svh
// Constants of the processor feature control block.
// Assumes inclusion by bare name; definitions only.
`ifndef FEATURE_CTL_REGS_SVH
`define FEATURE_CTL_REGS_SVH

`define FC_GROUP_ARCH_LAST 8'h0F
`define FC_GROUP_IMPL_FIRST 8'h10
`define FC_NUM_GROUPS 2
`define FC_GROUP_MAX 8'h10
`define FC_ST_OK 8'h00
`define FC_ST_OK_LARGER 8'h01
`define FC_ST_INVALID 8'hFE
`define FC_ST_BEYOND_MAX 8'hF8

`define FC_BIT_BUS_ERROR_SIGNAL_PROMO 63
`define FC_BIT_MCA_BUS_ERROR_SIGNAL 62
`define FC_BIT_MCA_BUS_INIT_SIGNAL 61
`define FC_BIT_CMCI_PROMO 60
`define FC_BIT_CACHE_OFF 59
`define FC_BIT_COHER_OFF 58
`define FC_BIT_PWR_GATE_OFF 57
`define FC_BIT_TIMEOUT_QUIET 56
`define FC_BIT_ENV_NOTIFY 55
`define FC_BIT_BRANCH_WAIT 47
`define FC_BIT_IFETCH_DEMAND 46
`define FC_BIT_DFETCH_DEMAND 45

// Group 0: bits 63..55 implemented and controllable, 47..45 implemented and controllable
`define FC_G0_AVAIL 64'hFF80_E000_0000_0000
`define FC_G0_CTRL 64'hFF80_E000_0000_0000
// Group 16: arbitrary implementation-specific layout
`define FC_G16_AVAIL 64'h0000_0000_0000_00FF
`define FC_G16_CTRL 64'h0000_0000_0000_000F
`define FC_RESET_VALUE 64'h0000_0000_0000_0000
// Steering outputs at reset: only power gating allowed
`define FC_STEER_RESET 8'h08

`endif

//--- common/feature_ctl_pkg.sv
// Types of the processor feature control block.
// Assumes nothing of its surroundings.
`default_nettype none
package feature_ctl_pkg;
    typedef struct packed {
        logic [63:0] avail;
        logic [63:0] status;
        logic [63:0] control;
        logic [7:0] code;
    } query_ans_s;

    typedef struct packed {
        logic bus_error_signal;
        logic bus_init_signal;
        logic machine_check_abort;
    } err_pins_s;

    typedef struct packed {
        logic [63:0] g0_r;
        logic [63:0] g16_r;
        query_ans_s ans_r;
        logic ans_valid_r;
        err_pins_s pins_r;
        logic [7:0] steer_r;
    } state_s;
endpackage
`default_nettype wire

//--- tb/feature_ctl_props.sv
// Port checker of the feature control block.
// Assumes binding into processor_feature_control.
`include "feature_ctl_regs.svh"
`default_nettype none
module feature_ctl_props (
    input wire logic clk,
    input wire logic nrst,
    input wire logic query_call,
    input wire logic update_call,
    input wire logic [7:0] feature_group,
    input wire logic [63:0] update_value,
    input wire logic error_check_entry,
    input wire logic bus_error_signal_signal_en,
    input wire logic bus_init_signal_signal_en,
    input wire logic ans_valid,
    input wire logic [63:0] ans_avail,
    input wire logic [63:0] ans_status,
    input wire logic [63:0] ans_control,
    input wire logic [7:0] ans_code,
    input wire logic bus_error_signal,
    input wire logic bus_init_signal,
    input wire logic cache_disable,
    input wire logic coherency_disable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence upd0;
        update_call && feature_group == 8'h00;
    endsequence
    AST_ANSWER: assert property ((query_call || update_call) |=> ans_valid) else $error("no answer");
    AST_INVALID: assert property (query_call && !update_call && feature_group inside {[8'h01:8'h0F]}
        |=> ans_code == `FC_ST_INVALID && ans_avail == 64'h0) else $error("bad invalid answer");
    AST_MASKS: assert property (ans_valid |-> ((ans_status | ans_control) & ~ans_avail) == 64'h0)
        else $error("unimplemented bit set");
    AST_STEER: assert property (upd0 |=> cache_disable == $past(update_value[59])) else $error("steer");
    AST_CACHE: assert property (cache_disable |-> coherency_disable) else $error("coherency on");
    AST_BUS_ERROR_SIGNAL_OFF: assert property (!bus_error_signal_signal_en |=> !bus_error_signal) else $error("bus_error_signal off");
    AST_BUS_INIT_SIGNAL_OFF: assert property (!bus_init_signal_signal_en |=> !bus_init_signal) else $error("bus_init_signal off");
    AST_ENTRY: assert property (error_check_entry && !update_call |=> $stable(cache_disable))
        else $error("entry changed setting");
endmodule
bind processor_feature_control feature_ctl_props i_props (.*);
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the feature control block.
// Assumes design and checker compiled first.
`include "feature_ctl_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, nrst, query_call, update_call, error_check_entry, init_event_entry, ans_valid;
    logic bus_error_event, mca_event, cmci_event, timeout_event, env_error_event, env_notify;
    logic bus_error_signal_signal_en, bus_init_signal_signal_en, mca_signal_en, bus_error_signal, bus_init_signal;
    logic machine_check_abort, cache_disable, coherency_disable, dynamic_power_gating_en;
    logic branch_predict_off, ifetch_prefetch_off, dfetch_prefetch_off;
    logic [7:0] feature_group, ans_code;
    logic [63:0] update_value, ans_avail, ans_status, ans_control;
    int mismatches = 0;
    int samples_checked = 0;
    processor_feature_control i_processor_feature_control (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic call(input logic upd, input logic [7:0] grp, input logic [63:0] val);
        @(posedge clk);
        query_call <= !upd;
        update_call <= upd;
        feature_group <= grp;
        update_value <= val;
        @(posedge clk);
        query_call <= 1'b0;
        update_call <= 1'b0;
        #1 chk("ans_valid", ans_valid, 64'h1);
    endtask
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_basic();
        call(1'b0, 8'h00, 64'h0);
        chk("avail", ans_avail, `FC_G0_AVAIL);
        chk("status", ans_status, `FC_RESET_VALUE);
        chk("control", ans_control, `FC_G0_CTRL);
        chk("code", ans_code, `FC_ST_OK);
        call(1'b1, 8'h00, '1);
        chk("merged", ans_status, `FC_G0_CTRL);
        chk("steer", {cache_disable, coherency_disable, dynamic_power_gating_en, branch_predict_off,
            ifetch_prefetch_off, dfetch_prefetch_off}, 6'h37);
        call(1'b1, 8'h10, '1);
        chk("group16", ans_status, `FC_G16_CTRL);
        $display("basic done");
    endtask
    task automatic t_groups();
        for (int g = 1; g < 16; g++) begin
            call(1'b0, 8'(g), 64'h0);
            chk("invalid", ans_avail | ans_status | 64'(ans_code), 64'(`FC_ST_INVALID));
        end
        call(1'b0, 8'h11, 64'h0);
        chk("beyond", ans_code, `FC_ST_BEYOND_MAX);
        $display("groups done");
    endtask
    // Row: setting bits 63..48, enables, event index, expected bus_error_signal bus_init_signal notify
    task automatic t_events();
        logic [27:0] tab [7] = '{28'h6000736, 28'h6000030, 28'h8000746, 28'h0000712, 28'h0100710,
            28'h0080701, 28'h1000720};
        foreach (tab[i]) begin
            call(1'b1, 8'h00, {tab[i][27:12], 48'h0});
            @(posedge clk);
            {bus_error_signal_signal_en, bus_init_signal_signal_en, mca_signal_en} <= tab[i][10:8];
            {bus_error_event, mca_event, cmci_event, timeout_event, env_error_event} <= 5'h01 << tab[i][7:4];
            @(posedge clk);
            {bus_error_event, mca_event, cmci_event, timeout_event, env_error_event} <= 5'h00;
            #1 chk("pins", {bus_error_signal, bus_init_signal, env_notify}, tab[i][3:0]);
        end
        chk("abort", machine_check_abort, 1'b1);
        @(posedge clk);
        {error_check_entry, init_event_entry} <= 2'h3;
        @(posedge clk);
        {error_check_entry, init_event_entry} <= 2'h0;
        call(1'b0, 8'h00, 64'h0);
        chk("kept", ans_status, 64'h1000_0000_0000_0000);
        $display("events done");
    endtask
    initial begin
        {query_call, update_call, error_check_entry, init_event_entry, feature_group, update_value} = '0;
        {bus_error_event, mca_event, cmci_event, timeout_event, env_error_event} = '0;
        {nrst, bus_error_signal_signal_en, bus_init_signal_signal_en, mca_signal_en} = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_basic();
        t_groups();
        t_events();
        close_out();
    end
    initial begin
        #200us;
        mismatches++;
        close_out();
    end
endmodule
`default_nettype wire
